//--- rtl/key_scan_pkg.sv
package key_scan_pkg;
  localparam int NUM_COLS = 16;
  localparam int NUM_ROWS = 4;
  // scan operand field positions
  localparam int OP_HR_EVERY_BIT = 6;
  localparam int OP_M7_BIT = 7;
  localparam int OP_M5_BIT = 5;
  localparam int OP_M4_BIT = 4;
  // mode codes over operand bits 7,5,4
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_ALL = 3'h1;
  localparam logic [2:0] MODE_OFF = 3'h2;
  localparam logic [2:0] MODE_QUAD = 3'h6;
  localparam logic [2:0] MODE_PAIR = 3'h7;
  // reset operand: mode 010, scanning off
  localparam logic [7:0] SCAN_OP_RESET = 8'h20;
  // clear-request operand that targets the key request flag
  localparam logic [7:0] CLR_KEY_REQ = 8'h20;
  // operand sources
  localparam logic [1:0] SRC_IMM = 2'h0;
  localparam logic [1:0] SRC_REG = 2'h1;
  localparam logic [1:0] SRC_TABLE = 2'h2;
  // default alternating-clock divider: 125 MHz / (32 Hz * 5 * 2)
  localparam int LCD_CLK_HZ = 125000000;
  localparam int FRAME_HZ = 32;
  localparam int DUTY_PHASES = 5;
  localparam int SCAN_HZ = FRAME_HZ * DUTY_PHASES * 2;
  localparam int SCAN_DIV = LCD_CLK_HZ / SCAN_HZ;
endpackage

//--- rtl/scan_phase_if.sv
`timescale 1ns/1ps
interface scan_phase_if;
  logic scanTick;
  logic scanEnd;
  modport src(output scanTick, output scanEnd);
  modport dst(input scanTick, input scanEnd);
endinterface

//--- rtl/scan_rate_gen.sv
`timescale 1ns/1ps
module scan_rate_gen
  import key_scan_pkg::*;
#(
  parameter int DIV = SCAN_DIV
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic run,
  scan_phase_if.src ph
);
  logic [31:0] cnt;
  logic half;

  // RULE17 - alternating clock divider
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 32'h0;
      half <= 1'b0;
    end else if (!run) begin
      cnt <= 32'h0;
      half <= 1'b0;
    end else if (cnt == 32'(DIV - 1)) begin
      cnt <= 32'h0;
      half <= ~half;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // drive phase starts, end pulse one period later
  assign ph.scanTick = run && (cnt == 32'(DIV - 1)) && !half;
  assign ph.scanEnd = run && (cnt == 32'(DIV - 1)) && half;

  a_tick_spacing: assert property (@(posedge mclk) disable iff (!arst_n) // RULE17
    ph.scanTick |=> !ph.scanTick)
    else $error("scan tick repeated");
endmodule

//--- rtl/key_matrix_scanner.sv
`timescale 1ns/1ps
// Operation
// RULE1 - four rows sensed, sixteen shared columns
// RULE2 - rows act as keys only when selected
// RULE3 - operand from immediate, register pair, table
// RULE4 - bit6 low: request only on key
// RULE5 - bit6 high: request every scan cycle
// RULE6 - mode 000 drives one selected column
// RULE7 - mode 001 drives all columns
// RULE8 - mode 010 disables scanning
// RULE9 - mode 10x drives eight columns
// RULE10 - mode 110 drives four columns
// RULE11 - mode 111 drives two columns
// RULE12 - software sets unused port pins output
// RULE13 - row rising sets key request flag
// RULE14 - enabled request sets start flag, releases halt
// RULE15 - rows latched into port latch each cycle
// RULE16 - clear command 20h clears request
// RULE17 - scan rate follows lcd alternating clock
// RULE18 - reset leaves scanning off, flag clear
module key_matrix_scanner
  import key_scan_pkg::*;
#(
  parameter int DIV = SCAN_DIV
) (
  input wire logic mclk,
  input wire logic arst_n,
  // scan operand load
  input wire logic loadScanType,
  input wire logic [1:0] loadSource,
  input wire logic [7:0] immOperand,
  input wire logic [3:0] accValue,
  input wire logic [3:0] regValue,
  input wire logic [7:0] tableValue,
  // control
  input wire logic keyInputSelect,
  input wire logic keyHaltReleaseEnable,
  input wire logic clearRequestCmd,
  input wire logic [7:0] clearOperand,
  input wire logic clearStartFlag,
  input wire logic [NUM_COLS-1:0] lcdSegIn,
  // pins
  input wire logic [NUM_ROWS-1:0] keyRowInputs,
  output logic [NUM_COLS-1:0] keyColumnOutputs,
  output logic [NUM_COLS-1:0] keyColumnScan,
  // status
  output logic [7:0] scanOperand,
  output logic keyHaltReleaseRequest,
  output logic keyStartConditionFlag,
  output logic keyScanStartFlag,
  output logic haltRelease,
  output logic [NUM_ROWS-1:0] portCLatch
);
  logic [NUM_ROWS-1:0] rowSync1;
  logic [NUM_ROWS-1:0] rowSync2;
  logic [NUM_ROWS-1:0] rowPrev;
  logic [NUM_COLS-1:0] colMask;
  logic [NUM_COLS-1:0] driveCols;
  logic [7:0] next_operand;
  logic scanRun;
  logic driving;
  logic keySeen;
  logic reqEvent;
  logic clrHit;
  logic [31:0] tickGap;
  logic seenTick;
  scan_phase_if ph();

  function automatic logic [2:0] scan_mode(input logic [7:0] op);
    scan_mode = {op[OP_M7_BIT], op[OP_M5_BIT], op[OP_M4_BIT]};
  endfunction

  // RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 - column decode
  function automatic logic [NUM_COLS-1:0] col_decode(input logic [7:0] op);
    logic [2:0] m;
    m = scan_mode(op);
    if (m == MODE_SINGLE) begin
      col_decode = 16'h0001 << op[3:0];
    end else if (m == MODE_ALL) begin
      col_decode = 16'hFFFF;
    end else if (m == MODE_OFF) begin
      col_decode = 16'h0000;
    end else if (m == MODE_QUAD) begin
      col_decode = 16'h000F << {op[3:2], 2'b00};
    end else if (m == MODE_PAIR) begin
      col_decode = 16'h0003 << {op[3:1], 1'b0};
    end else begin
      col_decode = op[3] ? 16'hFF00 : 16'h00FF;
    end
  endfunction

  // RULE3 - operand source select
  always_comb begin
    case (loadSource)
      SRC_IMM: next_operand = immOperand;
      SRC_REG: next_operand = {accValue, regValue};
      SRC_TABLE: next_operand = tableValue;
      default: next_operand = immOperand;
    endcase
  end

  // RULE18 - reset operand disables scanning
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scanOperand <= SCAN_OP_RESET;
    end else if (loadScanType) begin
      scanOperand <= next_operand;
    end
  end

  assign colMask = col_decode(scanOperand);
  // RULE2 - rows only serve as keys when selected
  assign scanRun = keyInputSelect && (scan_mode(scanOperand) != MODE_OFF);

  // RULE17 - scan timing from lcd alternating clock
  scan_rate_gen #(.DIV(DIV)) u_rate (
    .mclk(mclk),
    .arst_n(arst_n),
    .run(scanRun),
    .ph(ph)
  );

  // row pins are asynchronous, two flops before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rowSync1 <= '0;
      rowSync2 <= '0;
      rowPrev <= '0;
    end else begin
      rowSync1 <= keyRowInputs;
      rowSync2 <= rowSync1;
      rowPrev <= rowSync2;
    end
  end

  // RULE1 - scan phase drive window
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      driving <= 1'b0;
      driveCols <= '0;
    end else if (!scanRun || ph.scanEnd) begin
      driving <= 1'b0;
      driveCols <= '0;
    end else if (ph.scanTick) begin
      driving <= 1'b1;
      driveCols <= colMask;
    end
  end

  // RULE1 - columns steal the segment waveform while scanning
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      keyColumnOutputs <= '0;
      keyColumnScan <= '0;
    end else begin
      keyColumnOutputs <= (lcdSegIn & ~driveCols) | driveCols;
      keyColumnScan <= driveCols;
    end
  end

  // a held key shows one rise per scan, since its row falls between scans
  // RULE13 - hi-z to high on a row while driving
  assign keySeen = driving && |(rowSync2 & ~rowPrev);
  // RULE4 RULE5 - request source by operand bit 6
  assign reqEvent = scanOperand[OP_HR_EVERY_BIT] ? ph.scanEnd : keySeen;
  // RULE16 - clear only with operand 20h
  assign clrHit = clearRequestCmd && (clearOperand == CLR_KEY_REQ);

  // set wins over clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      keyHaltReleaseRequest <= 1'b0;
    end else if (reqEvent) begin
      keyHaltReleaseRequest <= 1'b1;
    end else if (clrHit) begin
      keyHaltReleaseRequest <= 1'b0;
    end
  end

  // RULE14 - enabled request sets start flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      keyStartConditionFlag <= 1'b0;
      keyScanStartFlag <= 1'b0;
    end else if (reqEvent && keyHaltReleaseEnable) begin
      keyStartConditionFlag <= 1'b1;
      keyScanStartFlag <= 1'b1;
    end else if (clearStartFlag) begin
      keyStartConditionFlag <= 1'b0;
      keyScanStartFlag <= 1'b0;
    end
  end

  // RULE14 - halt release pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      haltRelease <= 1'b0;
    end else begin
      haltRelease <= reqEvent && keyHaltReleaseEnable;
    end
  end

  // RULE15 - capture rows at end of cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      portCLatch <= '0;
    end else if (ph.scanEnd && keyInputSelect) begin
      portCLatch <= rowSync2;
    end
  end

  // RULE17 - tick spacing counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tickGap <= 32'h0;
      seenTick <= 1'b0;
    end else if (!scanRun) begin
      tickGap <= 32'h0;
      seenTick <= 1'b0;
    end else if (ph.scanTick) begin
      tickGap <= 32'h0;
      seenTick <= 1'b1;
    end else begin
      tickGap <= tickGap + 32'h1;
    end
  end

  // checks watch decoded state; row pins are seen only through the sync flops
  a_req_set: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
    reqEvent |=> keyHaltReleaseRequest)
    else $error("request not set");
  a_req_clear: assert property (@(posedge mclk) disable iff (!arst_n) // RULE16
    clrHit && !reqEvent |=> !keyHaltReleaseRequest)
    else $error("request not cleared");
  a_start_flag: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    reqEvent && keyHaltReleaseEnable |=> keyStartConditionFlag && haltRelease)
    else $error("start flag missing");
  a_no_start: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    !keyHaltReleaseEnable |=> !haltRelease)
    else $error("release without enable");
  a_clear_start: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    clearStartFlag && !(reqEvent && keyHaltReleaseEnable) |=> !keyStartConditionFlag)
    else $error("start flag not cleared");
  a_pulse_source: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    haltRelease |-> $past(reqEvent) && $past(keyHaltReleaseEnable))
    else $error("release without request");
  a_every_cycle: assert property (@(posedge mclk) disable iff (!arst_n) // RULE5
    scanOperand[OP_HR_EVERY_BIT] && ph.scanEnd |=> keyHaltReleaseRequest)
    else $error("no per-cycle request");
  a_key_only: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
    !scanOperand[OP_HR_EVERY_BIT] && !keySeen && !keyHaltReleaseRequest |=>
    !keyHaltReleaseRequest) else $error("spurious request");
  a_off_quiet: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
    scan_mode(scanOperand) == MODE_OFF |-> ##2 keyColumnScan == '0)
    else $error("scan while off");
  a_rows_gated: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
    !keyInputSelect |=> !driving && !ph.scanEnd)
    else $error("scan without key inputs");
  a_single_col: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
    ph.scanTick && scan_mode(scanOperand) == MODE_SINGLE |=>
    $countones(driveCols) == 1 && driveCols[$past(scanOperand[3:0])]) else $error("single column wrong");
  a_all_col: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
    ph.scanTick && scan_mode(scanOperand) == MODE_ALL |=> driveCols == 16'hFFFF)
    else $error("all columns wrong");
  a_half_cols: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
    ph.scanTick && scanOperand[OP_M7_BIT] && !scanOperand[OP_M5_BIT] |=>
    (driveCols == 16'h00FF || driveCols == 16'hFF00) && driveCols[8] == $past(scanOperand[3]))
    else $error("eight columns wrong");
  a_quad_cols: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    ph.scanTick && scan_mode(scanOperand) == MODE_QUAD |=>
    $countones(driveCols) == 4 && driveCols[{$past(scanOperand[3:2]), 2'h0}])
    else $error("four columns wrong");
  a_pair_cols: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
    ph.scanTick && scan_mode(scanOperand) == MODE_PAIR |=>
    $countones(driveCols) == 2 && driveCols[{$past(scanOperand[3:1]), 1'h0}])
    else $error("two columns wrong");
  a_col_out: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
    keyColumnScan != '0 |-> (keyColumnOutputs & keyColumnScan) == keyColumnScan)
    else $error("scanned column not driven");
  a_latch_rows: assert property (@(posedge mclk) disable iff (!arst_n) // RULE15
    ph.scanEnd && keyInputSelect |=> portCLatch == $past(rowSync2))
    else $error("row latch wrong");
  a_latch_hold: assert property (@(posedge mclk) disable iff (!arst_n) // RULE15
    !(ph.scanEnd && keyInputSelect) |=> $stable(portCLatch))
    else $error("row latch moved mid cycle");
  a_reset_off: assert property (@(posedge mclk) // RULE18
    $rose(arst_n) |-> scanOperand == SCAN_OP_RESET)
    else $error("reset operand");
  a_scan_period: assert property (@(posedge mclk) disable iff (!arst_n) // RULE17
    ph.scanTick && seenTick |-> tickGap == 32'(2 * DIV - 1))
    else $error("scan period wrong");
  a_end_spacing: assert property (@(posedge mclk) disable iff (!arst_n) // RULE17
    ph.scanEnd |-> tickGap == 32'(DIV - 1))
    else $error("scan end spacing wrong");

  // covers mark the scenarios the bench is meant to reach
  c_key_press: cover property (@(posedge mclk) disable iff (!arst_n) keySeen);
  c_every: cover property (@(posedge mclk) disable iff (!arst_n)
    scanOperand[OP_HR_EVERY_BIT] && ph.scanEnd);
  c_clear: cover property (@(posedge mclk) disable iff (!arst_n) clrHit);
  c_pair: cover property (@(posedge mclk) disable iff (!arst_n)
    driving && scan_mode(scanOperand) == MODE_PAIR);
  c_wake: cover property (@(posedge mclk) disable iff (!arst_n) haltRelease);
endmodule

//--- verification/key_matrix_model.sv
`timescale 1ns/1ps
module key_matrix_model
  import key_scan_pkg::*;
(
  // column drive and closed keys
  input wire logic [NUM_COLS-1:0] cols,
  input wire logic [NUM_ROWS*NUM_COLS-1:0] pressed,
  // sensed rows
  output logic [NUM_ROWS-1:0] rows
);
  // passive switch matrix
  // an open key leaves its row on the pull-low, never at the last value
  always_comb begin
    for (int r = 0; r < NUM_ROWS; r++) begin
      rows[r] = |(pressed[r*NUM_COLS +: NUM_COLS] & cols);
    end
  end
endmodule

//--- verification/key_matrix_scanner_tb.sv
`timescale 1ns/1ps
module key_matrix_scanner_tb;
  import key_scan_pkg::*;
  localparam int D = 4;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic loadScanType = 1'b0;
  logic [1:0] loadSource = SRC_IMM;
  logic [7:0] immOperand = 8'h00;
  logic [3:0] accValue = 4'h0;
  logic [3:0] regValue = 4'h0;
  logic [7:0] tableValue = 8'h00;
  logic keyInputSelect = 1'b0;
  logic keyHaltReleaseEnable = 1'b0;
  logic clearRequestCmd = 1'b0;
  logic [7:0] clearOperand = 8'h00;
  logic clearStartFlag = 1'b0;
  logic [NUM_COLS-1:0] lcdSegIn = 16'h0F0F;
  logic [NUM_ROWS-1:0] keyRowInputs, modelRows;
  logic [NUM_ROWS-1:0] rowForce = 4'h0;
  logic [NUM_COLS-1:0] keyColumnOutputs, keyColumnScan;
  logic [7:0] scanOperand;
  logic keyHaltReleaseRequest, keyStartConditionFlag, keyScanStartFlag, haltRelease;
  logic [NUM_ROWS-1:0] portCLatch;
  logic [NUM_ROWS*NUM_COLS-1:0] pressed = '0;
  int fails = 0;
  int comparisons = 0;
  int pulses = 0;
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (haltRelease === 1'b1) pulses++;
  // forced rows stand in for a key on a column the model cannot see
  assign keyRowInputs = modelRows | rowForce;
  key_matrix_model u_keys (.cols(keyColumnScan), .pressed(pressed), .rows(modelRows));
  key_matrix_scanner #(.DIV(D)) u_dut (.mclk, .arst_n, .loadScanType, .loadSource,
    .immOperand, .accValue, .regValue, .tableValue, .keyInputSelect,
    .keyHaltReleaseEnable, .clearRequestCmd, .clearOperand, .clearStartFlag, .lcdSegIn,
    .keyRowInputs, .keyColumnOutputs, .keyColumnScan, .scanOperand,
    .keyHaltReleaseRequest, .keyStartConditionFlag, .keyScanStartFlag, .haltRelease,
    .portCLatch);
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic waitFor(input int which);
    for (int i = 0; i < 64; i++) begin
      if (which == 0 && keyColumnScan !== '0) return;
      if (which == 1 && keyHaltReleaseRequest === 1'b1) return;
      step(1);
    end
    fails++;
    $display("MISMATCH wait %0d expected event seen none", which);
    test_done();
  endtask
  // only the chosen source carries the value, the others its inverse
  task automatic load(input logic [1:0] src, input logic [7:0] v);
    loadSource = src;
    immOperand = (src == SRC_IMM) ? v : ~v;
    {accValue, regValue} = (src == SRC_REG) ? v : ~v;
    tableValue = (src == SRC_TABLE) ? v : ~v;
    loadScanType = 1'b1;
    step(1);
    loadScanType = 1'b0;
    step(1);
    check("scanOperand", {8'h00, scanOperand}, {8'h00, v});
  endtask
  task automatic clr(input logic [7:0] v);
    clearOperand = v;
    clearRequestCmd = 1'b1;
    step(1);
    clearRequestCmd = 1'b0;
    step(1);
  endtask
  function automatic logic [15:0] colsFor(input logic [7:0] op);
    case ({op[7], op[5], op[4]})
      3'b000: return 16'h0001 << op[3:0];
      3'b001: return 16'hFFFF;
      3'b100, 3'b101: return op[3] ? 16'hFF00 : 16'h00FF;
      3'b110: return 16'h000F << {op[3:2], 2'b00};
      3'b111: return 16'h0003 << {op[3:1], 1'b0};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic modes();
    logic [7:0] ops [7] = '{8'h05, 8'h4F, 8'h10, 8'h88, 8'h98, 8'hA4, 8'hB7};
    for (int i = 0; i < 7; i++) begin
      load(SRC_IMM, 8'h20);
      step(3 * D + 4);
      check("scan off", keyColumnScan, 16'h0000);
      load(2'(i % 3), ops[i]);
      waitFor(0);
      check("keyColumnScan", keyColumnScan, colsFor(ops[i]));
      check("keyColumnOutputs", keyColumnOutputs, colsFor(ops[i]) | lcdSegIn);
    end
  endtask
  task automatic keyWake();
    load(SRC_IMM, 8'h10);
    clr(CLR_KEY_REQ);
    keyHaltReleaseEnable = 1'b1;
    pulses = 0;
    step(3 * D);
    check("idle request", keyHaltReleaseRequest, 1'b0);
    pressed[2*NUM_COLS+3] = 1'b1;
    waitFor(1);
    step(4 * D);
    check("startFlag", keyStartConditionFlag, 1'b1);
    check("scanStartFlag", keyScanStartFlag, 1'b1);
    check("wake pulse", pulses != 0, 1'b1);
    check("portCLatch", portCLatch, 4'h4);
    pressed = '0;
    step(4 * D);
    check("portCLatch", portCLatch, 4'h0);
    clr(8'h40);
    check("request kept", keyHaltReleaseRequest, 1'b1);
    clr(CLR_KEY_REQ);
    check("request cleared", keyHaltReleaseRequest, 1'b0);
    clearStartFlag = 1'b1;
    step(1);
    clearStartFlag = 1'b0;
    step(1);
    check("startFlag", keyStartConditionFlag, 1'b0);
  endtask
  task automatic everyScan();
    load(SRC_REG, 8'h50);
    waitFor(1);
    // no key is closed, so the rows latched at this cycle end stay low
    check("portCLatch", portCLatch, 4'h0);
    step(2);
    check("startFlag", keyStartConditionFlag, 1'b1);
    clr(CLR_KEY_REQ);
    check("request cleared", keyHaltReleaseRequest, 1'b0);
    pulses = 0;
    waitFor(1);
    step(1);
    check("every pulse", pulses != 0, 1'b1);
  endtask
  task automatic selectOff();
    keyInputSelect = 1'b0;
    load(SRC_IMM, 8'h10);
    clr(CLR_KEY_REQ);
    rowForce = 4'hF;
    step(6 * D);
    check("request", keyHaltReleaseRequest, 1'b0);
    check("select off scan", keyColumnScan, 16'h0000);
    rowForce = 4'h0;
  endtask
  initial begin
    step(8);
    arst_n = 1'b1;
    step(1);
    check("scanOperand", {8'h00, scanOperand}, {8'h00, SCAN_OP_RESET});
    step(3 * D);
    check("reset scan", keyColumnScan, 16'h0000);
    check("reset request", keyHaltReleaseRequest, 1'b0);
    // rows set as keys before scanning starts
    keyInputSelect = 1'b1;
    modes();
    keyWake();
    everyScan();
    selectOff();
    test_done();
  end
endmodule
